// >>> src/pcm_power_clock_manager.sv
// Summary of operation
// - master clock: chosen source, divided 1 to 64
// - master config write clears ready until established
// - cpu clock on/off by enable/disable, readable
// - cpu clock runs after reset, wakes on interrupt
// - cpu clock stops after current instruction ends
// - usb clock gated after lock, status shown
// - per-peripheral master clock gates with status
// - peripheral gate stops at once, off after reset
// - gate bit index equals peripheral identifier
// - three outputs, own source and divider
// - write one enables or disables each output
// - ready flag when output matches its config
// - oscillator enable, start-up eight times count
// - measurement counts main cycles over sixteen slow
// - pll input divider 0 to 255, zero off
// - pll factor 0 to 2047, zero off
// - lock after programmed slow cycles following write
// - pll reprogramming drops lock until relocked
// - usb divider divides pll by 1, 2, 4
// - oscillator counter on slow clock over eight
// - lock counter decrements per slow cycle
// - pll master source falls back to main while unlocked
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"

module pcm_power_clock_manager
	import pcm_pkg::*;
#(
	parameter int NPERIPH = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire logic slowClkIn,
	input wire logic mainClkIn,
	input wire logic pllClkIn,
	input wire logic irqWake,
	input wire logic instrDone,
	output logic masterClkEn,
	output logic cpuClkEn,
	output logic usbClkEn,
	output logic [NPERIPH-1:0] periphClkEn,
	output logic [`PCM_NPROG-1:0] progClkEn,
	output logic oscEnable,
	output logic [7:0] pllDivider,
	output logic [10:0] pllFactor,
	output logic [1:0] pllRange,
	output logic pmcIrq
);

	function automatic logic [31:0] laneMask(input logic [3:0] s);
		return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [31:0] m);
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic pickTick(input logic [1:0] sel,
		input logic s, input logic m, input logic p);
		case (sel)
			`PCM_SRC_SLOW: pickTick = s;
			`PCM_SRC_MAIN: pickTick = m;
			`PCM_SRC_PLL: pickTick = p;
			default: pickTick = 1'b0;
		endcase
	endfunction

	function automatic logic known(input logic [7:0] a);
		case (a)
			`PCM_SCER, `PCM_SCDR, `PCM_SCSR, `PCM_PCER, `PCM_PCDR,
			`PCM_PCSR, `PCM_MOR, `PCM_MCFR, `PCM_PLLR, `PCM_MCKR,
			`PCM_PCK0, `PCM_PCK1, `PCM_PCK2, `PCM_IER, `PCM_IDR,
			`PCM_SR, `PCM_IMR: known = 1'b1;
			default: known = 1'b0;
		endcase
	endfunction

	// clock pin synchronisers and edge detect
	logic [2:0] clkMeta, clkSync, clkPrev;
	logic slowTick, mainTick, pllTick;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			clkMeta <= 3'h0;
			clkSync <= 3'h0;
			clkPrev <= 3'h0;
		end
		else
		begin
			clkMeta <= {pllClkIn, mainClkIn, slowClkIn};
			clkSync <= clkMeta;
			clkPrev <= clkSync;
		end
	end

	assign slowTick = clkSync[0] & ~clkPrev[0];
	assign mainTick = clkSync[1] & ~clkPrev[1];
	assign pllTick = clkSync[2] & ~clkPrev[2];

	// bus slave
	logic awHave, wHave;
	logic [7:0] wrAddr;
	logic [31:0] wrData, wrMask, wSet;
	logic wrEn;

	assign awready = !awHave && !bvalid;
	assign wready = !wHave && !bvalid;
	assign arready = !rvalid;
	assign wrEn = awHave && wHave && !bvalid;
	assign wSet = wrData & wrMask;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			awHave <= 1'b0;
			wHave <= 1'b0;
			wrAddr <= 8'h0;
			wrData <= 32'h0;
			wrMask <= 32'h0;
			bvalid <= 1'b0;
			bresp <= `PCM_RESP_OKAY;
		end
		else
		begin
			if (awvalid && awready)
			begin
				awHave <= 1'b1;
				wrAddr <= {awaddr[7:2], 2'b00};
			end
			if (wvalid && wready)
			begin
				wHave <= 1'b1;
				wrData <= wdata;
				wrMask <= laneMask(wstrb);
			end
			if (wrEn)
			begin
				awHave <= 1'b0;
				wHave <= 1'b0;
				bvalid <= 1'b1;
				bresp <= known(wrAddr) ? `PCM_RESP_OKAY : `PCM_RESP_SLVERR;
			end
			else if (bvalid && bready)
				bvalid <= 1'b0;
		end
	end

	logic wrScer, wrScdr, wrMcc, wrPll, wrMor;
	logic [`PCM_NPROG-1:0] wrPck;
	assign wrScer = wrEn && wrAddr == `PCM_SCER;
	assign wrScdr = wrEn && wrAddr == `PCM_SCDR;
	assign wrMcc = wrEn && wrAddr == `PCM_MCKR;
	assign wrPll = wrEn && wrAddr == `PCM_PLLR;
	assign wrMor = wrEn && wrAddr == `PCM_MOR;
	assign wrPck = {wrEn && wrAddr == `PCM_PCK2,
		wrEn && wrAddr == `PCM_PCK1, wrEn && wrAddr == `PCM_PCK0};

	// system clock enables
	logic cpuOn, cpuStopPending, usbOn;
	logic [`PCM_NPROG-1:0] progOn;
	logic [NPERIPH-1:0] periphOn;
	logic [`PCM_NPROG-1:0] progSet, progClr;

	assign progSet = wrScer ? wSet[`PCM_SC_PROG +: `PCM_NPROG] : '0;
	assign progClr = wrScdr ? wSet[`PCM_SC_PROG +: `PCM_NPROG] : '0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cpuOn <= 1'b1;
			cpuStopPending <= 1'b0;
		end
		else if (irqWake || (wrScer && wSet[`PCM_SC_CPU]))
		begin
			cpuOn <= 1'b1;
			cpuStopPending <= 1'b0;
		end
		else if (cpuStopPending && instrDone)
		begin
			cpuOn <= 1'b0;
			cpuStopPending <= 1'b0;
		end
		else if (wrScdr && wSet[`PCM_SC_CPU] && cpuOn)
			cpuStopPending <= 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			usbOn <= 1'b0;
			progOn <= '0;
			periphOn <= '0;
		end
		else
		begin
			if (wrScer && wSet[`PCM_SC_USB])
				usbOn <= 1'b1;
			else if (wrScdr && wSet[`PCM_SC_USB])
				usbOn <= 1'b0;
			progOn <= (progOn & ~progClr) | progSet;
			if (wrEn && wrAddr == `PCM_PCER)
				periphOn <= periphOn | wSet[NPERIPH-1:0];
			else if (wrEn && wrAddr == `PCM_PCDR)
				periphOn <= periphOn & ~wSet[NPERIPH-1:0];
		end
	end

	// main oscillator start-up
	logic oscEn, oscStable;
	logic [7:0] oscCountCfg, oscCount;
	logic [2:0] oscDiv;
	logic [31:0] morNew;

	assign morNew = merge({16'h0, oscCountCfg, 7'h0, oscEn}, wrData, wrMask);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			oscEn <= 1'b0;
			oscCountCfg <= 8'h0;
			oscCount <= 8'h0;
			oscDiv <= 3'h0;
			oscStable <= 1'b0;
		end
		else if (wrMor)
		begin
			oscEn <= morNew[`PCM_MOR_EN];
			oscCountCfg <= morNew[`PCM_MOR_CNT_LO +: 8];
			oscCount <= morNew[`PCM_MOR_CNT_LO +: 8];
			oscDiv <= 3'h0;
			oscStable <= 1'b0;
		end
		else if (oscEn && !oscStable && slowTick)
		begin
			if (oscDiv == `PCM_OSC_DIV_LAST)
			begin
				oscDiv <= 3'h0;
				if (oscCount <= 8'h1)
					oscStable <= 1'b1;
				if (oscCount != 8'h0)
					oscCount <= oscCount - 8'h1;
			end
			else
				oscDiv <= oscDiv + 3'h1;
		end
	end

	// main clock frequency measurement
	logic measOn, measRdy;
	logic [15:0] measCnt;
	logic [4:0] measPer;

	always_ff @(posedge clk)
	begin
		if (!rst_n || !oscStable)
		begin
			measOn <= 1'b0;
			measRdy <= 1'b0;
			measCnt <= 16'h0;
			measPer <= 5'h0;
		end
		else if (!measOn && !measRdy && slowTick)
		begin
			measOn <= 1'b1;
			measCnt <= 16'h0;
			measPer <= 5'h0;
		end
		else if (measOn)
		begin
			measCnt <= measCnt + {15'h0, mainTick};
			if (slowTick)
			begin
				if (measPer == `PCM_MEAS_LAST)
				begin
					measOn <= 1'b0;
					measRdy <= 1'b1;
				end
				else
					measPer <= measPer + 5'h1;
			end
		end
	end

	// pll configuration and lock counter
	pcm_pll_t pllCfg, pllNew;
	logic [5:0] lockCnt;
	logic lock, pllOn;

	assign pllNew = pcm_pll_t'(merge({2'h0, pllCfg}, wrData, wrMask));
	assign pllOn = pllCfg.factor != 11'h0 && pllCfg.div != 8'h0;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			pllCfg <= '0;
			lockCnt <= 6'h0;
			lock <= 1'b0;
		end
		else if (wrPll)
		begin
			pllCfg <= pllNew;
			pllCfg.pad <= 1'b0;
			lockCnt <= pllNew.lockCount;
			lock <= 1'b0;
		end
		else if (pllOn && !lock && slowTick)
		begin
			if (lockCnt <= 6'h1)
				lock <= 1'b1;
			if (lockCnt != 6'h0)
				lockCnt <= lockCnt - 6'h1;
		end
	end

	// master clock selection and prescaler
	pcm_clksel_t mcc;
	logic [1:0] effSrc, effPrev;
	logic pllWait, mRestart, masterTick, masterReady;

	assign pllWait = mcc.src == `PCM_SRC_PLL && !lock;
	assign effSrc = pllWait ? `PCM_SRC_MAIN : mcc.src;
	assign mRestart = wrMcc || effSrc != effPrev;

	pcm_prescaler masterDiv (
		.clk(clk),
		.rst_n(rst_n),
		.restart(mRestart),
		.srcTick(pickTick(effSrc, slowTick, mainTick, pllTick)),
		.clock_divide_power(mcc.clock_divide_power),
		.outTick(masterTick)
	);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			mcc <= '0;
			effPrev <= `PCM_SRC_SLOW;
			masterReady <= 1'b1;
		end
		else
		begin
			if (wrMcc)
				mcc <= pcm_clksel_t'(merge({27'h0, mcc}, wrData, wrMask));
			effPrev <= effSrc;
			if (mRestart || pllWait)
				masterReady <= 1'b0;
			else if (masterTick)
				masterReady <= 1'b1;
		end
	end

	// usb clock divider
	logic usbTick;
	logic [2:0] usbPres;
	assign usbPres = (pllCfg.usbRatio == 2'h0) ? 3'h0 :
		(pllCfg.usbRatio == 2'h1) ? 3'h1 : 3'h2;

	pcm_prescaler usb_clock_ratio (
		.clk(clk),
		.rst_n(rst_n),
		.restart(wrPll),
		.srcTick(pllTick && lock),
		.clock_divide_power(usbPres),
		.outTick(usbTick)
	);

	// programmable clock outputs
	pcm_clksel_t progCfg [`PCM_NPROG];
	logic [`PCM_NPROG-1:0] progTick, progRdy;

	for (genvar i = 0; i < `PCM_NPROG; i++)
	begin : gProg
		pcm_prescaler progDiv (
			.clk(clk),
			.rst_n(rst_n),
			.restart(wrPck[i] || !progOn[i]),
			.srcTick(pickTick(progCfg[i].src, slowTick, mainTick,
				pllTick)),
			.clock_divide_power(progCfg[i].clock_divide_power),
			.outTick(progTick[i])
		);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < `PCM_NPROG; i++)
				progCfg[i] <= '0;
			progRdy <= '0;
		end
		else
		begin
			for (int i = 0; i < `PCM_NPROG; i++)
			begin
				if (wrPck[i])
					progCfg[i] <= pcm_clksel_t'(merge({27'h0, progCfg[i]},
						wrData, wrMask));
				if (wrPck[i] || !progOn[i])
					progRdy[i] <= 1'b0;
				else if (progTick[i])
					progRdy[i] <= 1'b1;
			end
		end
	end

	// interrupt mask and status
	logic [`PCM_SR_W-1:0] status, imr;
	assign status = {progRdy, 4'h0, masterReady, lock, 1'b0, oscStable};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			imr <= '0;
			pmcIrq <= 1'b0;
		end
		else
		begin
			if (wrEn && wrAddr == `PCM_IER)
				imr <= imr | wSet[`PCM_SR_W-1:0];
			else if (wrEn && wrAddr == `PCM_IDR)
				imr <= imr & ~wSet[`PCM_SR_W-1:0];
			pmcIrq <= |(status & imr);
		end
	end

	// gated clock enables
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			masterClkEn <= 1'b0;
			cpuClkEn <= 1'b0;
			usbClkEn <= 1'b0;
			periphClkEn <= '0;
			progClkEn <= '0;
		end
		else
		begin
			masterClkEn <= masterTick;
			cpuClkEn <= masterTick && cpuOn;
			usbClkEn <= usbTick && usbOn;
			periphClkEn <= {NPERIPH{masterTick}} & periphOn;
			progClkEn <= progTick & progOn;
		end
	end

	assign oscEnable = oscEn;
	assign pllDivider = pllCfg.div;
	assign pllFactor = pllCfg.factor;
	assign pllRange = pllCfg.range;

	// read path
	logic [31:0] rdNext;
	always_comb
	begin
		case ({araddr[7:2], 2'b00})
			`PCM_SCSR: rdNext = {21'h0, progOn, usbOn, 6'h0, cpuOn};
			`PCM_PCSR: rdNext = 32'(periphOn);
			`PCM_MOR: rdNext = {16'h0, oscCountCfg, 7'h0, oscEn};
			`PCM_MCFR: rdNext = {15'h0, measRdy, measCnt};
			`PCM_PLLR: rdNext = {2'h0, pllCfg};
			`PCM_MCKR: rdNext = {27'h0, mcc};
			`PCM_PCK0: rdNext = {27'h0, progCfg[0]};
			`PCM_PCK1: rdNext = {27'h0, progCfg[1]};
			`PCM_PCK2: rdNext = {27'h0, progCfg[2]};
			`PCM_SR: rdNext = {21'h0, status};
			`PCM_IMR: rdNext = {21'h0, imr};
			default: rdNext = 32'h0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			rvalid <= 1'b0;
			rdata <= 32'h0;
			rresp <= `PCM_RESP_OKAY;
		end
		else if (arvalid && arready)
		begin
			rvalid <= 1'b1;
			rdata <= rdNext;
			rresp <= known({araddr[7:2], 2'b00}) ? `PCM_RESP_OKAY :
				`PCM_RESP_SLVERR;
		end
		else if (rvalid && rready)
			rvalid <= 1'b0;
	end

endmodule
`default_nettype wire

// >>> src/pcm_consts.svh
`ifndef PCM_CONSTS_SVH
`define PCM_CONSTS_SVH

// register byte offsets
`define PCM_SCER 8'h00
`define PCM_SCDR 8'h04
`define PCM_SCSR 8'h08
`define PCM_PCER 8'h10
`define PCM_PCDR 8'h14
`define PCM_PCSR 8'h18
`define PCM_MOR 8'h20
`define PCM_MCFR 8'h24
`define PCM_PLLR 8'h2c
`define PCM_MCKR 8'h30
`define PCM_PCK0 8'h40
`define PCM_PCK1 8'h44
`define PCM_PCK2 8'h48
`define PCM_IER 8'h60
`define PCM_IDR 8'h64
`define PCM_SR 8'h68
`define PCM_IMR 8'h6c

// system clock bits
`define PCM_SC_CPU 0
`define PCM_SC_USB 7
`define PCM_SC_PROG 8

// status bits
`define PCM_SR_OSC 0
`define PCM_SR_LOCK 2
`define PCM_SR_MRDY 3
`define PCM_SR_PRDY 8
`define PCM_SR_W 11

// clock source encodings
`define PCM_SRC_SLOW 2'h0
`define PCM_SRC_MAIN 2'h1
`define PCM_SRC_PLL 2'h3

// oscillator config fields
`define PCM_MOR_EN 0
`define PCM_MOR_CNT_LO 8

// timing
`define PCM_OSC_DIV_LAST 3'h7
`define PCM_MEAS_LAST 5'h0f
`define PCM_CLOCK_DIVIDE_POWER_MAX 3'h6
`define PCM_NPROG 3

// bus answers
`define PCM_RESP_OKAY 2'h0
`define PCM_RESP_SLVERR 2'h2

`endif

// >>> src/pcm_pkg.sv
package pcm_pkg;

	typedef struct packed {
		logic [2:0] clock_divide_power;
		logic [1:0] src;
	} pcm_clksel_t;

	typedef struct packed {
		logic [1:0] usbRatio;
		logic pad;
		logic [10:0] factor;
		logic [1:0] range;
		logic [5:0] lockCount;
		logic [7:0] div;
	} pcm_pll_t;

endpackage

// >>> src/pcm_prescaler.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"

module pcm_prescaler
	import pcm_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic restart,
	input wire logic srcTick,
	input wire logic [2:0] clock_divide_power,
	output logic outTick
);

	logic [5:0] cnt;
	logic [5:0] limit;
	logic [2:0] presClamp;

	// power of two divide, 1 to 64
	always_comb
	begin
		presClamp = (clock_divide_power > `PCM_CLOCK_DIVIDE_POWER_MAX) ? `PCM_CLOCK_DIVIDE_POWER_MAX : clock_divide_power;
		limit = 6'((7'h1 << presClamp) - 7'h1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n || restart)
		begin
			cnt <= 6'h0;
			outTick <= 1'b0;
		end
		else
		begin
			outTick <= 1'b0;
			if (srcTick)
			begin
				if (cnt == limit)
				begin
					cnt <= 6'h0;
					outTick <= 1'b1;
				end
				else
					cnt <= cnt + 6'h1;
			end
		end
	end

endmodule
`default_nettype wire

// >>> tb/pcm_clk_source.sv
`timescale 1ns/1ps
`default_nettype none

module pcm_clk_source
	import pcm_pkg::*;
#(
	parameter int SLOW_HALF = 80,
	parameter int MAIN_HALF = 20,
	parameter int PLL_HALF = 15
)
(
	input wire logic oscEnable,
	input wire logic [7:0] pllDivider,
	input wire logic [10:0] pllFactor,
	output logic slowClk,
	output logic mainClk,
	output logic pllClk
);
	initial
	begin
		slowClk = 1'b0;
		forever #SLOW_HALF slowClk = !slowClk;
	end

	// main oscillator idle low until enabled
	initial
	begin
		mainClk = 1'b0;
		#7;
		forever #MAIN_HALF mainClk = oscEnable ? !mainClk : 1'b0;
	end

	// pll output low with divider or factor zero
	// offset keeps pll edges off the sampling clock edges
	initial
	begin
		pllClk = 1'b0;
		#3;
		forever #PLL_HALF pllClk = (oscEnable && pllDivider != 8'h0 &&
			pllFactor != 11'h0) ? !pllClk : 1'b0;
	end
endmodule

`default_nettype wire

// >>> tb/pcm_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"

module pcm_monitor
	import pcm_pkg::*;
#(
	parameter int NPERIPH = 32
)
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic irqWake,
	input wire logic masterClkEn,
	input wire logic cpuClkEn,
	input wire logic usbClkEn,
	input wire logic [NPERIPH-1:0] periphClkEn,
	input wire logic [`PCM_NPROG-1:0] progClkEn,
	input wire logic oscEnable,
	input wire logic [7:0] pllDivider,
	input wire logic [10:0] pllFactor,
	input wire logic pmcIrq
);
	logic wrTake;
	logic [10:0] wFactor;
	logic [7:0] wDiv;
	assign wrTake = awvalid && awready && wvalid && wready && wstrb == 4'hf;
	assign wFactor = wdata[26:16];
	assign wDiv = wdata[7:0];

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_reset_gates_off: assert property (disable iff (1'b0)
		!rst_n |=> periphClkEn == '0 && !usbClkEn && progClkEn == '0)
		else $error("clock gates active after reset");
	a_periph_on_master: assert property (
		periphClkEn != '0 |-> masterClkEn)
		else $error("peripheral pulse without master pulse");
	a_cpu_on_master: assert property (cpuClkEn |-> masterClkEn)
		else $error("cpu pulse without master pulse");
	a_cpu_wake_irq: assert property (
		irqWake && $past(irqWake) && $past(irqWake, 2) |->
		cpuClkEn == masterClkEn)
		else $error("cpu clock not restored by interrupt");
	a_pll_fields_out: assert property (
		wrTake && awaddr == `PCM_PLLR |-> ##2
		pllFactor == $past(wFactor, 2) && pllDivider == $past(wDiv, 2))
		else $error("pll fields not driven from config");
	a_osc_enable_out: assert property (
		wrTake && awaddr == `PCM_MOR |-> ##2
		oscEnable == $past(wdata[0], 2))
		else $error("oscillator enable not driven");
	a_irq_masked_off: assert property (
		wrTake && awaddr == `PCM_IDR && wdata == 32'hffffffff |=> ##2
		!pmcIrq)
		else $error("interrupt high with all masked");
	a_prog_stop_out: assert property (
		wrTake && awaddr == `PCM_SCDR && wdata[10:8] == 3'h7 |=> ##2
		(progClkEn == '0)[*4])
		else $error("programmable output still pulsing");
	a_usb_stop_out: assert property (
		wrTake && awaddr == `PCM_SCDR && wdata[7] |=> ##2
		(!usbClkEn)[*4])
		else $error("usb clock still pulsing");
	a_periph_stop_now: assert property (
		wrTake && awaddr == `PCM_PCDR && wdata == 32'hffffffff |=> ##2
		(periphClkEn == '0)[*4])
		else $error("peripheral clock still pulsing");
endmodule

bind pcm_power_clock_manager pcm_monitor #(.NPERIPH(NPERIPH)) pcm_monitor_inst (
	.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
	.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
	.wready(wready), .irqWake(irqWake), .masterClkEn(masterClkEn),
	.cpuClkEn(cpuClkEn), .usbClkEn(usbClkEn), .periphClkEn(periphClkEn),
	.progClkEn(progClkEn), .oscEnable(oscEnable), .pllDivider(pllDivider),
	.pllFactor(pllFactor), .pmcIrq(pmcIrq)
);

`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcm_consts.svh"

module tb
	import pcm_pkg::*;
;
	logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid, irqWake, instrDone;
	logic slowClk, mainClk, pllClk, masterClkEn, cpuClkEn, usbClkEn;
	logic oscEnable, pmcIrq;
	logic [7:0] awaddr, araddr, pllDivider;
	logic [31:0] wdata, rdata, periphClkEn;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, pllRange, resp;
	logic [2:0] progClkEn;
	logic [10:0] pllFactor;
	int nFail, checks, cyc;

	pcm_power_clock_manager #(.NPERIPH(32)) pcm_power_clock_manager_inst (
		.clk(clk), .rst_n(rst_n), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.slowClkIn(slowClk), .mainClkIn(mainClk), .pllClkIn(pllClk),
		.irqWake(irqWake), .instrDone(instrDone), .masterClkEn(masterClkEn),
		.cpuClkEn(cpuClkEn), .usbClkEn(usbClkEn), .periphClkEn(periphClkEn),
		.progClkEn(progClkEn), .oscEnable(oscEnable),
		.pllDivider(pllDivider), .pllFactor(pllFactor),
		.pllRange(pllRange), .pmcIrq(pmcIrq));

	pcm_clk_source pcm_clk_source_inst (.oscEnable(oscEnable),
		.pllDivider(pllDivider), .pllFactor(pllFactor), .slowClk(slowClk),
		.mainClk(mainClk), .pllClk(pllClk));

	initial
	begin
		clk = 1'b0;
		forever #5 clk = !clk;
	end

	always @(posedge clk)
		cyc <= cyc + 1;

	task automatic testDone();
		$display("checks %0d mismatches %0d", checks, nFail);
		if (nFail == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic cmp(input string s, input logic [31:0] e, g);
		checks++;
		if (g !== e)
		begin
			nFail++;
			$display("mismatch %s expected %h seen %h", s, e, g);
		end
	endtask

	task automatic tmo(input string s);
		nFail++;
		$display("mismatch %s expected answer seen timeout", s);
		testDone();
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 50);
		resp = bresp;
		if (!bvalid)
			tmo("write");
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		int n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(posedge clk);
			if (arready)
				arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 50);
		d = rdata;
		resp = rresp;
		if (!rvalid)
			tmo("read");
	endtask

	task automatic rc(input string s, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		cmp(s, e, v);
	endtask

	task automatic poll(input logic [7:0] a, input int b);
		logic [31:0] v;
		int n = 0;
		do
		begin
			rd(a, v);
			n++;
		end while (v[b] !== 1'b1 && n < 500);
		if (v[b] !== 1'b1)
			tmo("poll");
	endtask

	task automatic gap(input logic sel, input logic [31:0] e);
		int n, t[$];
		for (n = 0; n < 900 && t.size() < 3; n++)
		begin
			@(posedge clk);
			if (sel ? progClkEn[0] : masterClkEn)
				t.push_back(n);
		end
		cmp("period", e, (t.size() < 3) ? 32'h0 : 32'(t[2] - t[1]));
	endtask

	task automatic tReset();
		rc("scsr", `PCM_SCSR, 32'h1);
		rc("pcsr", `PCM_PCSR, 32'h0);
		rc("sr", `PCM_SR, 32'h8);
		rc("pllr", `PCM_PLLR, 32'h0);
	endtask

	task automatic tPeriph();
		int n;
		wr(`PCM_PCER, 32'h110);
		rc("pcsr", `PCM_PCSR, 32'h110);
		wr(`PCM_PCDR, 32'h10);
		rc("pcsr", `PCM_PCSR, 32'h100);
		for (n = 0; n < 100 && masterClkEn !== 1'b1; n++)
			@(posedge clk);
		cmp("periph", 32'h100, periphClkEn);
		cmp("cpuclk", 32'h1, {31'h0, cpuClkEn});
		wr(`PCM_PCDR, 32'hffffffff);
		rc("pcsr", `PCM_PCSR, 32'h0);
	endtask

	task automatic tCpu();
		wr(`PCM_SCDR, 32'h1);
		rc("cpu", `PCM_SCSR, 32'h1);
		instrDone <= 1'b1;
		@(posedge clk);
		instrDone <= 1'b0;
		rc("cpu", `PCM_SCSR, 32'h0);
		irqWake <= 1'b1;
		repeat (3) @(posedge clk);
		irqWake <= 1'b0;
		rc("cpu", `PCM_SCSR, 32'h1);
	endtask

	task automatic tOsc();
		int t;
		wr(`PCM_MOR, 32'h701);
		rc("sr", `PCM_SR, 32'h8);
		t = cyc;
		poll(`PCM_SR, `PCM_SR_OSC);
		t = cyc - t;
		cmp("osc", 32'h1, {31'h0, t >= 768 && t <= 940});
		poll(`PCM_MCFR, 16);
		rc("mcfr", `PCM_MCFR, 32'h10040);
	endtask

	task automatic tPll();
		int t;
		wr(`PCM_PLLR, 32'h40805);
		rc("lock", `PCM_SR, 32'h9);
		t = cyc;
		poll(`PCM_SR, `PCM_SR_LOCK);
		t = cyc - t;
		cmp("lock", 32'h1, {31'h0, t >= 112 && t <= 176});
		rc("pllr", `PCM_PLLR, 32'h40805);
		wr(`PCM_SCER, 32'h80);
		rc("usb", `PCM_SCSR, 32'h81);
		for (t = 0; t < 50 && usbClkEn !== 1'b1; t++)
			@(posedge clk);
		cmp("usb", 32'h1, {31'h0, usbClkEn});
		wr(`PCM_SCDR, 32'h80);
		wr(`PCM_MCKR, 32'h3);
		poll(`PCM_SR, `PCM_SR_MRDY);
		wr(`PCM_PLLR, 32'h4c805);
		rc("relock", `PCM_SR, 32'h1);
		cmp("range", 32'h3, {30'h0, pllRange});
		poll(`PCM_SR, `PCM_SR_LOCK);
		poll(`PCM_SR, `PCM_SR_MRDY);
		wr(`PCM_MCKR, 32'h5);
		rc("mrdy", `PCM_SR, 32'h5);
		poll(`PCM_SR, `PCM_SR_MRDY);
		gap(1'b0, 32'h8);
		wr(`PCM_MCKR, 32'h19);
		poll(`PCM_SR, `PCM_SR_MRDY);
		gap(1'b0, 32'h100);
	endtask

	task automatic tProg();
		wr(`PCM_PCK0, 32'h7);
		wr(`PCM_SCER, 32'h100);
		rc("prog", `PCM_SCSR, 32'h101);
		poll(`PCM_SR, `PCM_SR_PRDY);
		gap(1'b1, 32'h6);
		wr(`PCM_SCDR, 32'h700);
		rc("prog", `PCM_SCSR, 32'h1);
		rc("prdy", `PCM_SR, 32'hd);
	endtask

	task automatic tIrq();
		wr(`PCM_IER, 32'h8);
		rc("imr", `PCM_IMR, 32'h8);
		cmp("irq", 32'h1, {31'h0, pmcIrq});
		wr(`PCM_IDR, 32'hffffffff);
		rc("imr", `PCM_IMR, 32'h0);
		cmp("irq", 32'h0, {31'h0, pmcIrq});
		wr(8'h7c, 32'h1);
		cmp("bresp", 32'h2, {30'h0, resp});
		rc("unmapped", 8'h7c, 32'h0);
		cmp("rresp", 32'h2, {30'h0, resp});
	endtask

	initial
	begin
		rst_n = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = 8'h0;
		araddr = 8'h0;
		wdata = 32'h0;
		wstrb = 4'hf;
		irqWake = 1'b0;
		instrDone = 1'b0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		tReset();
		tPeriph();
		tCpu();
		tOsc();
		tPll();
		tProg();
		tIrq();
		testDone();
	end
endmodule

`default_nettype wire
